//--- rtl/abod_top.sv
`timescale 1ns/10ps
`default_nettype none
module abod_top
  import abod_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               instr_valid,
  input  wire logic [INSTR_W-1:0] instr_word,
  output logic                    instr_ready,
  output logic                    skip_next,
  output abod_fm_req_t            fm_req,
  input  wire logic [DATA_W-1:0]  fm_rdata,
  output logic [DATA_W-1:0]       acc_out,
  output abod_flags_t             flags_out
);

  abod_regs_t r;
  abod_regs_t n;

  // Returns {carry, half_carry, sum}.
  function automatic logic [DATA_W+1:0] add8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic [DATA_W:0] full;
    logic [4:0]      low;
    full = {1'b0, a} + {1'b0, b};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {full[DATA_W], low[4], full[DATA_W-1:0]};
  endfunction

  logic              ahb_take;
  logic [REG_AW-1:0] ahb_off;
  logic              ahb_mapped;
  logic [31:0]       rd_mux;

  assign ahb_take   = hsel & hready & htrans[1];
  assign ahb_off    = haddr[REG_AW-1:0];
  assign ahb_mapped = (haddr[31:REG_AW] == '0);

  always_comb begin
    rd_mux = RDATA_NONE;
    if (ahb_mapped) begin
      case (ahb_off)
        ADDR_ACC: begin
          rd_mux[DATA_W-1:0] = r.acc;
        end
        ADDR_STATUS: begin
          rd_mux[STAT_CARRY] = r.flags.carry;
          rd_mux[STAT_HALF]  = r.flags.half_carry;
          rd_mux[STAT_ZERO]  = r.flags.zero;
          rd_mux[STAT_BUSY]  = (r.state != ABOD_IDLE);
        end
        ADDR_CTRL: begin
          rd_mux[CTRL_ENABLE] = r.enable;
        end
        default: begin
          rd_mux = RDATA_NONE;
        end
      endcase
    end
  end

  logic [DATA_W+1:0]  sum;
  logic [DATA_W-1:0]  result;
  logic [DATA_W-1:0]  opnd;
  logic [BIT_W-1:0]   bnum;
  logic               tbit;
  logic [INSTR_W-1:0] w;

  always_comb begin
    n          = r;
    n.fm.rd_en = 1'b0;
    n.fm.wr_en = 1'b0;
    n.skip     = 1'b0;
    sum        = '0;
    result     = '0;
    opnd       = '0;
    bnum       = '0;
    tbit       = 1'b0;
    w          = r.instr;

    // Bus data phase first, so an instruction retiring in the same cycle overrides software.
    if (r.wr_pend) begin
      case (r.wr_addr)
        ADDR_ACC: begin
          n.acc = hwdata[DATA_W-1:0];
        end
        ADDR_STATUS: begin
          n.flags.carry      = hwdata[STAT_CARRY];
          n.flags.half_carry = hwdata[STAT_HALF];
          n.flags.zero       = hwdata[STAT_ZERO];
        end
        ADDR_CTRL: begin
          n.enable = hwdata[CTRL_ENABLE];
        end
        default: begin
          n.wr_pend = 1'b0;
        end
      endcase
    end
    n.wr_pend = ahb_take & hwrite & ahb_mapped;
    n.wr_addr = ahb_off;
    if (ahb_take && !hwrite) begin
      n.hrdata = rd_mux;
    end

    case (r.state)
      ABOD_IDLE: begin
        n.instr_ready = n.enable;
        if (r.instr_ready && instr_valid) begin
          w       = instr_word;
          n.instr = instr_word;
          opnd    = w[IMM_HI:0];
          if (w[GRP_HI -: 2] == GRP_LIT && w[OP_HI -: 3] == OP_ADD_IMM) begin
            sum                = add8(r.acc, opnd);
            n.acc              = sum[DATA_W-1:0];
            n.flags.carry      = sum[DATA_W+1];
            n.flags.half_carry = sum[DATA_W];
            n.flags.zero       = (sum[DATA_W-1:0] == '0);
          end else if (w[GRP_HI -: 2] == GRP_LIT && w[OP_HI -: 4] == OP_AND_IMM) begin
            result       = r.acc & opnd;
            n.acc        = result;
            n.flags.zero = (result == '0);
          end else if ((w[GRP_HI -: 2] == GRP_BYTE
                        && (w[OP_HI -: 4] == OP_ADD_FILE || w[OP_HI -: 4] == OP_AND_FILE))
                       || w[GRP_HI -: 2] == GRP_BIT) begin
            n.fm.addr     = w[FADDR_HI:0];
            n.fm.rd_en    = 1'b1;
            n.instr_ready = 1'b0;
            n.state       = ABOD_READ;
          end
        end
      end
      ABOD_READ: begin
        n.state = ABOD_EXEC;
      end
      ABOD_EXEC: begin
        bnum          = w[BITNUM_HI -: BIT_W];
        tbit          = fm_rdata[bnum];
        n.state       = ABOD_IDLE;
        n.instr_ready = n.enable;
        n.fm.wdata    = fm_rdata;
        if (w[GRP_HI -: 2] == GRP_BIT) begin
          case (w[OP_HI -: 2])
            BOP_CLEAR: begin
              n.fm.wdata[bnum] = 1'b0;
              n.fm.wr_en       = 1'b1;
            end
            BOP_SET: begin
              n.fm.wdata[bnum] = 1'b1;
              n.fm.wr_en       = 1'b1;
            end
            BOP_SKIP_ZERO: begin
              if (!tbit) begin
                n.skip        = 1'b1;
                n.instr_ready = 1'b0;
                n.state       = ABOD_NOP;
              end
            end
            BOP_SKIP_ONE: begin
              if (tbit) begin
                n.skip        = 1'b1;
                n.instr_ready = 1'b0;
                n.state       = ABOD_NOP;
              end
            end
            default: begin
              n.state = ABOD_IDLE;
            end
          endcase
          // Flags are left as they are for every bit operation.
        end else begin
          if (w[OP_HI -: 4] == OP_ADD_FILE) begin
            sum                = add8(r.acc, fm_rdata);
            result             = sum[DATA_W-1:0];
            n.flags.carry      = sum[DATA_W+1];
            n.flags.half_carry = sum[DATA_W];
          end else begin
            result = r.acc & fm_rdata;
          end
          n.flags.zero = (result == '0);
          if (w[DEST_POS] == DEST_ACC) begin
            n.acc = result;
          end else begin
            n.fm.wdata = result;
            n.fm.wr_en = 1'b1;
          end
        end
      end
      ABOD_NOP: begin
        // The discarded instruction's slot is spent idle.
        n.state       = ABOD_IDLE;
        n.instr_ready = n.enable;
      end
      default: begin
        n.state       = ABOD_IDLE;
        n.instr_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.state       <= ABOD_IDLE;
      r.instr       <= '0;
      r.acc         <= ACC_RST;
      r.flags       <= '0;
      r.enable      <= ENABLE_RST;
      r.fm          <= '0;
      r.instr_ready <= 1'b0;
      r.skip        <= 1'b0;
      r.wr_pend     <= 1'b0;
      r.wr_addr     <= '0;
      r.hrdata      <= RDATA_NONE;
    end else begin
      r <= n;
    end
  end

  // The slave never stretches a transfer, so these are constant flops.
  logic hreadyout_reg;
  logic hresp_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= HRESP_OKAY;
    end
  end

  assign hreadyout   = hreadyout_reg;
  assign hresp       = hresp_reg;
  assign hrdata      = r.hrdata;
  assign instr_ready = r.instr_ready;
  assign skip_next   = r.skip;
  assign fm_req      = r.fm;
  assign acc_out     = r.acc;
  assign flags_out   = r.flags;

endmodule
`default_nettype wire

//--- rtl/abod_pkg.sv
// How it works
// - Add-immediate adds the accumulator and an eight-bit literal, writes the accumulator and updates carry, half_carry and zero.
// - Add-file adds the accumulator to the file register at a 7-bit address and updates carry, half_carry and zero.
// - A file-register arithmetic or logic result goes to the accumulator when the destination bit is 0 and back to the file register when it is 1.
// - And-immediate ANDs the accumulator with an eight-bit literal into the accumulator and updates only zero.
// - And-file ANDs the accumulator with the addressed file register, routes the result by the destination bit and updates only zero.
// - Bit-clear forces the chosen bit 0 to 7 of the addressed file register to zero and leaves the other bits and all flags alone.
// - Bit-set forces the chosen bit 0 to 7 of the addressed file register to one and leaves the other bits and all flags alone.
// - Skip-if-bit-one lets the next instruction run when the bit is 0 and, when it is 1, discards it and runs a no-operation, taking one extra cycle.
// - Skip-if-bit-zero lets the next instruction run when the bit is 1 and, when it is 0, discards it and runs a no-operation, taking one extra cycle.
// - The bit-test skips leave every flag unchanged whatever the outcome.
// - Bit operations are decoded from a 14-bit word with top bits 01, then clear 00, set 01, skip-if-zero 10 or skip-if-one 11, a 3-bit bit number and a 7-bit address.
// - When a conditional test is true the second cycle is executed as a no-operation.
package abod_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FILE_AW = 7;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned BIT_W   = 3;

  // Instruction word fields.
  localparam int unsigned GRP_HI    = 13;
  localparam int unsigned OP_HI     = 11;
  localparam int unsigned DEST_POS  = 7;
  localparam int unsigned BITNUM_HI = 9;
  localparam int unsigned FADDR_HI  = 6;
  localparam int unsigned IMM_HI    = 7;

  localparam logic [1:0] GRP_BYTE      = 2'h0;
  localparam logic [1:0] GRP_BIT       = 2'h1;
  localparam logic [1:0] GRP_LIT       = 2'h3;
  localparam logic [3:0] OP_ADD_FILE   = 4'h7;
  localparam logic [3:0] OP_AND_FILE   = 4'h5;
  localparam logic [3:0] OP_AND_IMM    = 4'h9;
  localparam logic [2:0] OP_ADD_IMM    = 3'h7;
  localparam logic [1:0] BOP_CLEAR     = 2'h0;
  localparam logic [1:0] BOP_SET       = 2'h1;
  localparam logic [1:0] BOP_SKIP_ZERO = 2'h2;
  localparam logic [1:0] BOP_SKIP_ONE  = 2'h3;
  localparam logic       DEST_ACC      = 1'b0;

  // Register map, byte addresses within the block's window.
  localparam int unsigned REG_AW      = 8;
  localparam logic [7:0]  ADDR_ACC    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_CTRL   = 8'h08;
  localparam int unsigned STAT_CARRY  = 0;
  localparam int unsigned STAT_HALF   = 1;
  localparam int unsigned STAT_ZERO   = 2;
  localparam int unsigned STAT_BUSY   = 3;
  localparam int unsigned CTRL_ENABLE = 0;

  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic              ENABLE_RST = 1'b1;
  localparam logic [31:0]       RDATA_NONE = 32'h00000000;
  localparam logic              HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ABOD_IDLE = 2'b00,
    ABOD_READ = 2'b01,
    ABOD_EXEC = 2'b10,
    ABOD_NOP  = 2'b11
  } abod_state_t;

  typedef struct packed {
    logic               carry;
    logic               half_carry;
    logic               zero;
  } abod_flags_t;

  typedef struct packed {
    logic [FILE_AW-1:0] addr;
    logic               rd_en;
    logic               wr_en;
    logic [DATA_W-1:0]  wdata;
  } abod_fm_req_t;

  typedef struct packed {
    abod_state_t        state;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0]  acc;
    abod_flags_t        flags;
    logic               enable;
    abod_fm_req_t       fm;
    logic               instr_ready;
    logic               skip;
    logic               wr_pend;
    logic [REG_AW-1:0]  wr_addr;
    logic [31:0]        hrdata;
  } abod_regs_t;

endpackage

//--- verification/abod_properties.sv
`timescale 1ns/10ps
`default_nettype none
module abod_properties
  import abod_pkg::*;
(
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               instr_valid,
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic               instr_ready,
  input wire logic               skip_next,
  input wire abod_fm_req_t       fm_req,
  input wire logic [DATA_W-1:0]  fm_rdata,
  input wire logic [DATA_W-1:0]  acc_out,
  input wire abod_flags_t        flags_out
);
  logic       tk;
  logic [2:0] bsel;
  assign tk = instr_valid && instr_ready;
  // No new word is taken while one is in flight, so the latched bit number stays valid.
  always_ff @(posedge hclk) if (tk) bsel <= instr_word[9:7];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read;
    fm_req.rd_en ##1 1'b1;
  endsequence
  a_bit_clear: assert property (tk && instr_word[13:10] == {GRP_BIT, BOP_CLEAR} ##1 s_read
    |=> fm_req.wr_en && fm_req.wdata == ($past(fm_rdata) & ~(8'h01 << bsel)))
    else $error("bit clear wrote a wrong byte");
  a_bit_set: assert property (tk && instr_word[13:10] == {GRP_BIT, BOP_SET} ##1 s_read
    |=> fm_req.wr_en && fm_req.wdata == ($past(fm_rdata) | (8'h01 << bsel)))
    else $error("bit set wrote a wrong byte");
  a_skip_one: assert property (tk && instr_word[13:10] == {GRP_BIT, BOP_SKIP_ONE} ##1 s_read
    |=> skip_next == $past(fm_rdata[bsel]))
    else $error("skip on one decided wrongly");
  a_skip_zero: assert property (tk && instr_word[13:10] == {GRP_BIT, BOP_SKIP_ZERO} ##1 s_read
    |=> skip_next == !$past(fm_rdata[bsel]))
    else $error("skip on zero decided wrongly");
  a_bit_flags_hold: assert property (tk && instr_word[13:12] == GRP_BIT |=> $stable(flags_out)[*3])
    else $error("bit operation changed a flag");
  // The idle slot is the cycle in which skip_next stands; the port opens again one cycle later.
  a_skip_nop: assert property (skip_next |-> !instr_ready && !fm_req.rd_en && !fm_req.wr_en ##1 instr_ready)
    else $error("skipped slot was not a single idle cycle");
  a_add_imm: assert property (tk && instr_word[13:9] == 5'h1F |=>
    {flags_out.carry, acc_out} == 9'($past(acc_out)) + 9'($past(instr_word[7:0]))
    && flags_out.half_carry == (5'($past(acc_out[3:0])) + 5'($past(instr_word[3:0])) > 5'h0F)
    && flags_out.zero == (acc_out == 8'h00))
    else $error("add immediate result or flags wrong");
  a_and_imm: assert property (tk && instr_word[13:8] == 6'h39 |=> acc_out == ($past(acc_out) &
    $past(instr_word[7:0])) && flags_out.zero == (acc_out == 8'h00) && flags_out[2:1] == $past(flags_out[2:1]))
    else $error("and immediate result or flags wrong");
  a_add_file_dest: assert property (tk && instr_word[13:8] == 6'h07 ##1 s_read |=>
    {flags_out.carry, ($past(instr_word[7], 3) ? fm_req.wdata : acc_out)} ==
    9'($past(acc_out, 3)) + 9'($past(fm_rdata)) && fm_req.wr_en == $past(instr_word[7], 3))
    else $error("add file result or destination wrong");
endmodule
bind abod_top abod_properties abod_properties_inst (.hclk, .hresetn, .instr_valid, .instr_word,
  .instr_ready, .skip_next, .fm_req, .fm_rdata, .acc_out, .flags_out);
`default_nettype wire

//--- verification/abod_fmem.sv
`timescale 1ns/10ps
`default_nettype none
// Synchronous file memory; between reads the data lines toggle so a stale byte never looks fresh.
module abod_fmem
  import abod_pkg::*;
(
  input  wire logic         hclk,
  input  wire abod_fm_req_t fm_req,
  output logic [DATA_W-1:0] fm_rdata
);
  logic [DATA_W-1:0] mem [128];
  initial begin
    fm_rdata = 8'h5A;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 91);
  end
  always @(posedge hclk) begin
    if (fm_req.rd_en) fm_rdata <= mem[fm_req.addr];
    else fm_rdata <= ~fm_rdata;
    if (fm_req.wr_en) mem[fm_req.addr] <= fm_req.wdata;
  end
endmodule
`default_nettype wire

//--- verification/test_add_and_bit_ops_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module test_add_and_bit_ops_datapath
  import abod_pkg::*;
;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic               instr_valid = 1'b0, skip_seen = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        haddr = 32'h0, hwdata = 32'h0, seed = 32'h9BAB, rd, hrdata;
  logic [INSTR_W-1:0] instr_word = 14'h0;
  logic               hreadyout, hresp, instr_ready, skip_next;
  logic [DATA_W-1:0]  fm_rdata, acc_out;
  abod_fm_req_t       fm_req;
  abod_flags_t        flags_out;
  int                 fail_count = 0, check_count = 0, cyc = 0, acc_m = 0, fl_m = 0;
  int                 mem_m [128];

  abod_top abod_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instr_valid, .instr_word, .instr_ready,
    .skip_next, .fm_req, .fm_rdata, .acc_out, .flags_out);
  abod_fmem abod_fmem_inst (.hclk, .fm_req, .fm_rdata);

  always #2 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (skip_next === 1'b1) skip_seen = 1'b1;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input int exp);
    check_count++;
    if (seen !== 32'(exp)) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Ops 0..3 are add/and with literal or file, 4..7 the bit operations.
  function automatic logic [INSTR_W-1:0] mk(input logic [2:0] op, input logic [31:0] r);
    logic [5:0] hi [4];
    hi = '{6'h3E, 6'h39, 6'h07, 6'h05};
    if (op[2]) return {GRP_BIT, op[1:0], r[9:0]};
    return {hi[op[1:0]] | {5'h0, op == 3'h0 && r[8]}, r[7:0]};
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic exec(input logic [INSTR_W-1:0] w);
    int a, f, o, r, b, sk, n;
    a = acc_m;
    f = mem_m[w[6:0]];
    o = w[13] ? int'(w[7:0]) : f;
    b = w[9:7];
    sk = 0;
    skip_seen = 1'b0;
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge hclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 9);
    casez (w)
      14'b11_111?_????_????, 14'b00_0111_????_????: begin
        r = a + o;
        fl_m = {r > 255, a % 16 + o % 16 > 15, r % 256 == 0};
      end
      14'b11_1001_????_????, 14'b00_0101_????_????: begin
        r = a & o;
        fl_m = fl_m & 6 | (r == 0);
      end
      14'b01_00??_????_????: mem_m[w[6:0]] = f & ~(1 << b);
      14'b01_01??_????_????: mem_m[w[6:0]] = f | 1 << b;
      default: sk = (f >> b & 1) == w[10];
    endcase
    if (w[13] || w[13:12] == 2'h0 && !w[7]) acc_m = r % 256;
    else if (w[13:12] == 2'h0) mem_m[w[6:0]] = r % 256;
    chk("acc", acc_out, acc_m);
    chk("flags", flags_out, fl_m);
    chk("skip", skip_seen, sk);
    @(negedge hclk);
    chk("file", abod_fmem_inst.mem[w[6:0]], mem_m[w[6:0]]);
    @(posedge hclk);
  endtask

  initial begin
    for (int i = 0; i < 128; i++) mem_m[i] = (i * 37 + 91) % 256;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'(ADDR_CTRL), 32'h0, rd);
    chk("ctrl", rd, 1);
    ahb(1'b0, 32'h100, 32'h0, rd);
    chk("unmapped", rd, 0);
    chk("hresp", hresp, 0);
    ahb(1'b1, 32'(ADDR_ACC), 32'hFF, rd);
    acc_m = 255;
    exec(14'h3E01);
    for (int i = 0; i < 150; i++) begin
      seed = rnd(seed);
      exec(mk(i < 8 ? 3'(i) : seed[2:0], seed >> 3));
    end
    ahb(1'b0, 32'(ADDR_ACC), 32'h0, rd);
    chk("acc_read", rd, acc_m);
    ahb(1'b1, 32'(ADDR_STATUS), 32'h5, rd);
    ahb(1'b0, 32'(ADDR_STATUS), 32'h0, rd);
    chk("status", rd, 5);
    chk("flags_wr", flags_out, 5);
    ahb(1'b1, 32'(ADDR_CTRL), 32'h0, rd);
    @(posedge hclk);
    chk("ready_off", instr_ready, 0);
    ahb(1'b0, 32'(ADDR_CTRL), 32'h0, rd);
    chk("ctrl_off", rd, 0);
    close_out();
  end
endmodule
`default_nettype wire
